/* rtl/adcsq_top.sv */
// Operation
// - End flag sets after one single conversion or a full scan pass.
// - Writing zero after reading the flag as one clears it.
// - A DMA read of a result register, started by interrupt, clears it.
// - Interrupt request is flag and enable; enable resets to zero.
// - Single mode: start runs one conversion, then clears itself.
// - Scan mode: start cycles the group until cleared, reset, standby.
// - Results are 10 bits left-justified in 16, low bits zero, RO.
`timescale 1ns/10ps
module adcsq_top (
    input wire logic clk_sys_i,          // System clock, 40 MHz.
    input wire logic rstn_i,             // Async reset, active low.
    input wire logic standby_i,          // Standby, stops conversion.
    input wire logic [27:0] addr_i,      // Register address.
    input wire logic [15:0] wdata_i,     // Write data.
    input wire logic wr_i,               // Write strobe.
    input wire logic rd_i,               // Read strobe.
    input wire logic dma_rd_i,           // Current read is by DMA.
    input wire logic [9:0] adc_data_i,   // Converter result.
    output logic [15:0] rdata_o,         // Read data, cycle after rd.
    output logic [2:0] chan_sel_o,       // Analog input select.
    output logic conv_busy_o,            // Conversion in progress.
    output logic conv_done_irq_o,        // Conversion-complete request.
    output logic irq_o                   // Level interrupt.
);
    typedef struct packed {
        logic end_flag;
        logic irq_en;
        logic start;
        logic scan;
        logic conv_clock_select;
        logic [2:0] ch;
        logic read_seen;
        logic [3:0][15:0] result;
        logic [2:0] chan;
        adcsq_pkg::adcsq_state_t st;
        logic tmr_start;
        logic done_irq;
        logic [15:0] rdata;
    } adcsq_main_t;
    adcsq_main_t q, n;

    logic tmr_done;
    logic tmr_busy;
    logic abort;
    logic ev_end;
    logic ev_chan;
    logic clr_sw;
    logic clr_dma;
    logic csr_wr;
    logic [adcsq_pkg::IRQ_W-1:0] irq_stat;
    logic [adcsq_pkg::IRQ_W-1:0] irq_mask;

    // True when the address hits one of the four result registers.
    function automatic logic is_result(input logic [27:0] a);
        is_result = (a == adcsq_pkg::OFS_RES_A) ||
                    (a == adcsq_pkg::OFS_RES_B) ||
                    (a == adcsq_pkg::OFS_RES_C) ||
                    (a == adcsq_pkg::OFS_RES_D);
    endfunction : is_result

    // Result register index from its address.
    function automatic logic [1:0] result_idx(input logic [27:0] a);
        result_idx = a[2:1];
    endfunction : result_idx

    // First input of the selected half for scan mode.
    function automatic logic [2:0] scan_base(input logic [2:0] c);
        scan_base = {c[2], 2'b00};
    endfunction : scan_base

    assign csr_wr = wr_i && (addr_i == adcsq_pkg::OFS_CSR);

    // A zero write clears the flag only after software has seen it set, so a
    // blind zero write cannot lose a completion it never saw.
    assign clr_sw = csr_wr && !wdata_i[adcsq_pkg::BIT_END]
                    && q.read_seen;
    assign clr_dma = rd_i && dma_rd_i && is_result(addr_i)
                     && q.done_irq;

    // Sequencer events, computed from state and the timer pulse.
    always_comb begin
        ev_chan = 1'b0;
        ev_end = 1'b0;
        abort = standby_i;
        if (q.st == adcsq_pkg::ST_CONV) begin
            if (!q.start) begin
                abort = 1'b1;
            end else if (tmr_done) begin
                ev_chan = 1'b1;
                ev_end = !q.scan
                         || (q.chan[1:0] == q.ch[1:0]);
            end
        end
        if (standby_i) begin
            ev_chan = 1'b0;
            ev_end = 1'b0;
        end
    end

    // Next state: bus reads and writes first, then the sequencer,
    // then standby, which overrides control and state but not the results, channel or read data.
    always_comb begin
        n = q;
        n.tmr_start = 1'b0;
        n.rdata = '0;
        if (rd_i) begin
            if (is_result(addr_i)) begin
                n.rdata = q.result[result_idx(addr_i)];
            end else if (addr_i == adcsq_pkg::OFS_CSR) begin
                n.rdata = {8'h00, q.end_flag, q.irq_en, q.start,
                           q.scan, q.conv_clock_select, q.ch};
                if (q.end_flag) begin
                    n.read_seen = 1'b1;
                end
            end else if (addr_i == adcsq_pkg::OFS_IRQ_STAT) begin
                n.rdata = {14'h0000, irq_stat};
            end else if (addr_i == adcsq_pkg::OFS_IRQ_MASK) begin
                n.rdata = {14'h0000, irq_mask};
            end
        end
        if (csr_wr) begin
            n.irq_en = wdata_i[adcsq_pkg::BIT_IE];
            n.start = wdata_i[adcsq_pkg::BIT_START];
            n.scan = wdata_i[adcsq_pkg::BIT_SCAN];
            n.conv_clock_select = wdata_i[adcsq_pkg::BIT_CKS];
            n.ch = wdata_i[2:0];
        end
        unique case (q.st)
            adcsq_pkg::ST_IDLE: begin
                if (q.start) begin
                    n.st = adcsq_pkg::ST_CONV;
                    n.tmr_start = 1'b1;
                    // In scan mode the low bits are a count, not a
                    // channel, so the pass opens at the half's base.
                    n.chan = q.scan ? scan_base(q.ch)
                                    : q.ch;
                end
            end
            adcsq_pkg::ST_CONV: begin
                if (abort) begin
                    n.st = adcsq_pkg::ST_IDLE;
                end else if (tmr_done) begin
                    n.result[q.chan[1:0]] = {adc_data_i,
                        6'h00};
                    if (!q.scan) begin
                        n.start = 1'b0;
                        n.st = adcsq_pkg::ST_IDLE;
                    end else begin
                        n.tmr_start = 1'b1;
                        n.chan = ev_end ? scan_base(q.ch)
                                        : q.chan + 3'h1;
                    end
                end
            end
        endcase
        if (clr_sw || clr_dma) begin
            n.end_flag = 1'b0;
            n.read_seen = 1'b0;
        end
        // A completion in the clearing cycle wins over the clear.
        if (ev_end) begin
            n.end_flag = 1'b1;
        end
        if (standby_i) begin
            n.end_flag = adcsq_pkg::CSR_RESET[adcsq_pkg::BIT_END];
            n.irq_en = adcsq_pkg::CSR_RESET[adcsq_pkg::BIT_IE];
            n.start = adcsq_pkg::CSR_RESET[adcsq_pkg::BIT_START];
            n.scan = adcsq_pkg::CSR_RESET[adcsq_pkg::BIT_SCAN];
            n.conv_clock_select = adcsq_pkg::CSR_RESET[adcsq_pkg::BIT_CKS];
            n.ch = adcsq_pkg::CSR_RESET[2:0];
            n.read_seen = 1'b0;
            n.st = adcsq_pkg::ST_IDLE;
            n.tmr_start = 1'b0;
        end
        n.done_irq = n.end_flag && n.irq_en;
    end

    // Reset loads the documented control value and clear results.
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            q <= '0;
            q.irq_en <= adcsq_pkg::CSR_RESET[adcsq_pkg::BIT_IE];
            q.ch <= adcsq_pkg::CSR_RESET[2:0];
            q.chan <= adcsq_pkg::CSR_RESET[2:0];
            q.result <= {4{adcsq_pkg::RESULT_RESET}};
            q.st <= adcsq_pkg::ST_IDLE;
        end else begin
            q <= n;
        end
    end

    // Conversion timing; the analog sample itself lives outside.
    adcsq_conv_timer u_timer (
        .clk_sys_i (clk_sys_i),
        .rstn_i    (rstn_i),
        .start_i   (q.tmr_start),
        .cks_i     (q.conv_clock_select),
        .abort_i   (abort),
        .done_o    (tmr_done),
        .busy_o    (tmr_busy)
    );

    // Sticky status: end of a pass and each stored result.
    adcsq_irq_ctrl #(
        .N (adcsq_pkg::IRQ_W)
    ) u_irq (
        .clk_sys_i (clk_sys_i),
        .rstn_i    (rstn_i),
        .event_i   ({ev_chan, ev_end}),
        .wr_stat_i (wr_i && (addr_i == adcsq_pkg::OFS_IRQ_STAT)),
        .wr_mask_i (wr_i && (addr_i == adcsq_pkg::OFS_IRQ_MASK)),
        .wdata_i   (wdata_i[adcsq_pkg::IRQ_W-1:0]),
        .stat_o    (irq_stat),
        .mask_o    (irq_mask),
        .irq_o     (irq_o)
    );

    // Outputs come straight from state flops.
    assign rdata_o = q.rdata;
    assign chan_sel_o = q.chan;
    assign conv_busy_o = (q.st == adcsq_pkg::ST_CONV);
    assign conv_done_irq_o = q.done_irq;

    // Single mode: one result sets the flag and drops start.
    a_single_end: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (q.st == adcsq_pkg::ST_CONV && tmr_done && q.start
         && !q.scan && !standby_i)
        |=> (q.end_flag && !q.start && !conv_busy_o))
        else $error("single conversion end not flagged");

    // Scan pass end wraps to the half base and flags.
    // A write in that cycle may clear start, so it is left out.
    a_scan_wrap: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (q.st == adcsq_pkg::ST_CONV && tmr_done && q.start && !csr_wr
         && q.scan && !standby_i && q.chan[1:0] == q.ch[1:0])
        |=> (q.end_flag && q.start && chan_sel_o == {q.ch[2], 2'b00}))
        else $error("scan pass did not wrap or flag");

    // Mid-pass a scan steps to the next input without flagging.
    a_scan_step: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (q.st == adcsq_pkg::ST_CONV && tmr_done && q.start && q.scan
         && !standby_i && q.chan[1:0] != q.ch[1:0] && !q.end_flag
         && !csr_wr)
        |=> (chan_sel_o == $past(q.chan) + 3'h1 && !q.end_flag))
        else $error("scan did not step");

    // A write of one never sets the flag.
    a_write_no_set: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (csr_wr && wdata_i[adcsq_pkg::BIT_END] && !q.end_flag
         && !ev_end) |=> !q.end_flag)
        else $error("flag set by a write");

    // Zero written without a prior read of one keeps the flag.
    a_clear_unseen: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (csr_wr && q.end_flag && !q.read_seen && !clr_dma
         && !standby_i) |=> q.end_flag)
        else $error("flag cleared without a read");

    // Read of one then zero write clears the flag.
    a_clear_after_read: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (rd_i && addr_i == adcsq_pkg::OFS_CSR && q.end_flag
         && !ev_end ##1 csr_wr && !wdata_i[adcsq_pkg::BIT_END]
         && !ev_end) |=> !q.end_flag)
        else $error("flag not cleared after read");

    // DMA read of a result clears the flag it was started by.
    a_dma_clear: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (rd_i && dma_rd_i && is_result(addr_i) && conv_done_irq_o
         && !ev_end) |=> !q.end_flag && !conv_done_irq_o)
        else $error("dma access did not clear flag");

    // Request follows flag and enable, on the same edge as either.
    a_irq_gate: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        ##1 (conv_done_irq_o == ($past(n.end_flag) && $past(n.irq_en))))
        else $error("interrupt request not gated");

    // Stored result is justified with zero low bits.
    a_result_just: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (ev_chan) |=> (q.result[$past(q.chan[1:0])]
        == {$past(adc_data_i), 6'h00}))
        else $error("result not left-justified");

    // The timer never runs while the sequencer is idle.
    a_timer_idle: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (q.st == adcsq_pkg::ST_IDLE) |-> !tmr_busy)
        else $error("timer busy while idle");

    // Standby stops the sequencer and drops flag and request.
    a_standby_stop: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        standby_i |=> (!conv_busy_o && !q.start && !q.end_flag
                       && !conv_done_irq_o))
        else $error("standby did not stop conversion");

    // Standby leaves the stored results alone.
    a_standby_keep: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        standby_i |=> (q.result == $past(q.result)))
        else $error("standby changed a result");

    // A bus write to a result register changes nothing.
    a_result_ro: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (wr_i && is_result(addr_i) && !ev_chan)
        |=> (q.result == $past(q.result)))
        else $error("result register took a write");

    // Single mode converts the channel that the field names.
    a_chan_single: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (q.st == adcsq_pkg::ST_IDLE && q.start && !q.scan && !standby_i)
        |=> (conv_busy_o && chan_sel_o == $past(q.ch)))
        else $error("single mode input wrong");

    // Scan mode opens each pass at the base of the chosen half.
    a_chan_scan: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (q.st == adcsq_pkg::ST_IDLE && q.start && q.scan && !standby_i)
        |=> (conv_busy_o && chan_sel_o == {$past(q.ch[2]), 2'b00}))
        else $error("scan did not open at half base");

    // Clearing start in flight drops the conversion, nothing stored.
    a_abort_drop: assert property (
        @(posedge clk_sys_i) disable iff (!rstn_i)
        (q.st == adcsq_pkg::ST_CONV && !q.start)
        |=> (!conv_busy_o && q.result == $past(q.result)))
        else $error("aborted conversion left a trace");
endmodule : adcsq_top

/* include/adcsq_pkg.sv */
package adcsq_pkg;
    // Register map, printed offsets used as addresses.
    localparam int ADDR_W = 28;
    localparam int DATA_W = 16;
    localparam logic [27:0] OFS_RES_A = 28'h5FFFEE0;
    localparam logic [27:0] OFS_RES_B = 28'h5FFFEE2;
    localparam logic [27:0] OFS_RES_C = 28'h5FFFEE4;
    localparam logic [27:0] OFS_RES_D = 28'h5FFFEE6;
    localparam logic [27:0] OFS_CSR = 28'h5FFFEF8;
    localparam logic [27:0] OFS_IRQ_STAT = 28'h5FFFEFA;
    localparam logic [27:0] OFS_IRQ_MASK = 28'h5FFFEFC;
    // Control/status field positions and reset value.
    localparam int BIT_END = 7;
    localparam int BIT_IE = 6;
    localparam int BIT_START = 5;
    localparam int BIT_SCAN = 4;
    localparam int BIT_CKS = 3;
    localparam logic [7:0] CSR_RESET = 8'h04;
    localparam logic [15:0] RESULT_RESET = 16'h0000;
    // Result left-justified: ten bits above six zero bits.
    localparam int RES_LSB = 6;
    // Conversion length in clock cycles per clock select.
    localparam logic [7:0] CONV_CYC_SLOW = 8'hEC;
    localparam logic [7:0] CONV_CYC_FAST = 8'h86;
    // Interrupt status bits.
    localparam int IRQ_W = 2;
    localparam int IRQ_END = 0;
    localparam int IRQ_CHAN = 1;
    typedef enum logic {ST_IDLE, ST_CONV} adcsq_state_t;
endpackage : adcsq_pkg

/* rtl/adcsq_conv_timer.sv */
`timescale 1ns/10ps
module adcsq_conv_timer (
    input wire logic clk_sys_i, // System clock.
    input wire logic rstn_i,    // Async reset, active low.
    input wire logic start_i,   // Begin one conversion.
    input wire logic cks_i,     // Fast conversion clock.
    input wire logic abort_i,   // Drop conversion in flight.
    output logic done_o,        // One-cycle end pulse.
    output logic busy_o         // Conversion in flight.
);
    typedef struct packed {
        logic busy;
        logic done;
        logic [7:0] cnt;
    } adcsq_tmr_t;
    adcsq_tmr_t q, n;

    // Length is latched at start so a later select change waits.
    always_comb begin
        n = q;
        n.done = 1'b0;
        if (abort_i) begin
            n.busy = 1'b0;
        end else if (start_i) begin
            n.busy = 1'b1;
            n.cnt = (cks_i ? adcsq_pkg::CONV_CYC_FAST
                           : adcsq_pkg::CONV_CYC_SLOW) - 8'h01;
        end else if (q.busy) begin
            if (q.cnt == 8'h00) begin
                n.busy = 1'b0;
                n.done = 1'b1;
            end else begin
                n.cnt = q.cnt - 8'h01;
            end
        end
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign done_o = q.done;
    assign busy_o = q.busy;

    a_slow_length: assert property (@(posedge clk_sys_i)
        disable iff (!rstn_i) (start_i && !cks_i && !abort_i)
        |-> ##237 (done_o || !busy_o))
        else $error("slow conversion length wrong");
    a_fast_early: assert property (@(posedge clk_sys_i)
        disable iff (!rstn_i) (start_i && cks_i && !abort_i)
        |=> !done_o [*8])
        else $error("fast conversion ended too early");
endmodule : adcsq_conv_timer

/* rtl/adcsq_irq_ctrl.sv */
`timescale 1ns/10ps
module adcsq_irq_ctrl #(
    parameter int N = 2
) (
    input wire logic clk_sys_i,       // System clock.
    input wire logic rstn_i,          // Async reset, active low.
    input wire logic [N-1:0] event_i, // Event pulses.
    input wire logic wr_stat_i,       // Write one to clear status.
    input wire logic wr_mask_i,       // Write mask.
    input wire logic [N-1:0] wdata_i, // Write data.
    output logic [N-1:0] stat_o,      // Sticky status.
    output logic [N-1:0] mask_o,      // Enable mask.
    output logic irq_o                // Level interrupt.
);
    typedef struct packed {
        logic [N-1:0] stat;
        logic [N-1:0] mask;
        logic irq;
    } adcsq_irq_t;
    adcsq_irq_t q, n;

    // An event in the clearing cycle survives: set wins over clear.
    always_comb begin
        n = q;
        if (wr_stat_i) begin
            n.stat = q.stat & ~wdata_i;
        end
        n.stat = n.stat | event_i;
        if (wr_mask_i) begin
            n.mask = wdata_i;
        end
        n.irq = |(n.stat & n.mask);
    end

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            q <= '0;
        end else begin
            q <= n;
        end
    end

    assign stat_o = q.stat;
    assign mask_o = q.mask;
    assign irq_o = q.irq;
endmodule : adcsq_irq_ctrl

/* bench/adcsq_mux_model.sv */
`timescale 1ns/10ps
module adcsq_mux_model (
    input wire logic clk_sys_i,        // System clock.
    input wire logic [2:0] chan_sel_i, // Selected analog input.
    input wire logic busy_i,           // Conversion in progress.
    output logic [9:0] adc_data_o      // Converter result.
);
    logic [9:0] noise_r;

    // Outside a conversion the lines carry a pattern that flips every cycle,
    // so a sample taken at the wrong moment can match by luck only the level of input 2.
    initial noise_r = 10'h155;
    always @(posedge clk_sys_i) begin
        noise_r <= ~noise_r;
    end

    // Each input carries a level that encodes its own number.
    assign adc_data_o = busy_i ?
        {chan_sel_i, ~chan_sel_i, chan_sel_i, 1'b1} : noise_r;
endmodule : adcsq_mux_model

/* bench/testbench.sv */
`timescale 1ns/10ps
module testbench;
    logic clk_sys_i = 1'b0;
    logic rstn_i = 1'b0;
    logic standby_i = 1'b0;
    logic [27:0] addr_i = 28'h0000000;
    logic [15:0] wdata_i = 16'h0000;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic dma_rd_i = 1'b0;
    logic [9:0] adc_data_i;
    logic [15:0] rdata_o;
    logic [2:0] chan_sel_o;
    logic conv_busy_o;
    logic conv_done_irq_o;
    logic irq_o;
    int mismatches = 0;
    int check_count = 0;
    logic [15:0] rv;

    // A 40 MHz system clock.
    always #12.5 clk_sys_i = ~clk_sys_i;

    adcsq_top adcsq_top_inst (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
        .standby_i(standby_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .dma_rd_i(dma_rd_i),
        .adc_data_i(adc_data_i), .rdata_o(rdata_o), .chan_sel_o(chan_sel_o),
        .conv_busy_o(conv_busy_o), .conv_done_irq_o(conv_done_irq_o),
        .irq_o(irq_o));

    adcsq_mux_model adcsq_mux_model_inst (.clk_sys_i(clk_sys_i),
        .chan_sel_i(chan_sel_o), .busy_i(conv_busy_o),
        .adc_data_o(adc_data_i));

    // Expected register image of the level that the model gives an input.
    function automatic logic [15:0] exp_res(input logic [2:0] ch);
        return {ch, ~ch, ch, 1'b1, 6'h00};
    endfunction : exp_res

    task automatic check(input string name, input logic [15:0] seen,
                         input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic wr_reg(input logic [27:0] a, input logic [15:0] d);
        @(posedge clk_sys_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
    endtask : wr_reg

    // The data are taken at the edge that closes the cycle after the strobe.
    task automatic rd_reg(input logic [27:0] a, output logic [15:0] d,
                          input logic dma = 1'b0);
        @(posedge clk_sys_i);
        addr_i <= a;
        rd_i <= 1'b1;
        dma_rd_i <= dma;
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
        dma_rd_i <= 1'b0;
        @(posedge clk_sys_i);
        d = rdata_o;
    endtask : rd_reg

    task automatic wait_busy(input logic lvl);
        int n;
        n = 0;
        while (conv_busy_o !== lvl && n < 20) begin
            @(posedge clk_sys_i);
            n++;
        end
        check("conv_busy_o", {15'h0, conv_busy_o}, {15'h0, lvl});
    endtask : wait_busy

    task automatic t_reset();
        rd_reg(adcsq_pkg::OFS_CSR, rv);
        check("csr reset", rv, 16'h0004);
        for (int i = 0; i < 4; i++) begin
            rd_reg(adcsq_pkg::OFS_RES_A + 28'(2 * i), rv);
            check("result reset", rv, 16'h0000);
        end
        rd_reg(28'h5FFFEF0, rv);
        check("unmapped", rv, 16'h0000);
        wr_reg(adcsq_pkg::OFS_RES_A, 16'hFFC0);
        rd_reg(adcsq_pkg::OFS_RES_A, rv);
        check("result read-only", rv, 16'h0000);
    endtask : t_reset

    // One single conversion; csr holds start, clock select and channel.
    task automatic t_single(input logic [7:0] csr, input int n);
        int cnt;
        logic [2:0] ch;
        cnt = 0;
        wr_reg(adcsq_pkg::OFS_CSR, {8'h00, csr});
        wait_busy(1'b1);
        ch = chan_sel_o;
        while (conv_busy_o === 1'b1 && cnt < 400) begin
            @(posedge clk_sys_i);
            cnt++;
        end
        check("chan_sel_o", {13'h0, ch}, {13'h0, csr[2:0]});
        check("length", 16'(cnt >= n && cnt <= n + 2), 16'h1);
        rd_reg(adcsq_pkg::OFS_CSR, rv);
        check("flag", {15'h0, rv[7]}, 16'h1);
        check("csr end", rv, {8'h00, (csr & 8'hDF) | 8'h80});
        rd_reg(adcsq_pkg::OFS_RES_A + 28'({csr[1:0], 1'b0}), rv);
        check("result", rv, exp_res(csr[2:0]));
    endtask : t_single

    task automatic t_flag();
        wr_reg(adcsq_pkg::OFS_CSR, 16'h0082);
        rd_reg(adcsq_pkg::OFS_CSR, rv);
        check("flag write one", rv, 16'h0082);
        // Read of one and the clearing write back to back, no gap.
        @(posedge clk_sys_i);
        addr_i <= adcsq_pkg::OFS_CSR;
        rd_i <= 1'b1;
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
        wdata_i <= 16'h0002;
        wr_i <= 1'b1;
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
        check("flag read", rdata_o, 16'h0082);
        rd_reg(adcsq_pkg::OFS_CSR, rv);
        check("flag cleared", rv, 16'h0002);
        wr_reg(adcsq_pkg::OFS_CSR, 16'h0082);
        rd_reg(adcsq_pkg::OFS_CSR, rv);
        check("flag not set", rv, 16'h0002);
    endtask : t_flag

    task automatic t_irq();
        t_single(8'h2B, 134);
        check("req masked", {15'h0, conv_done_irq_o}, 16'h0);
        rd_reg(adcsq_pkg::OFS_IRQ_STAT, rv);
        check("irq status", rv, 16'h0003);
        check("irq_o masked", {15'h0, irq_o}, 16'h0);
        wr_reg(adcsq_pkg::OFS_IRQ_MASK, 16'h0001);
        wr_reg(adcsq_pkg::OFS_CSR, 16'h00CB);
        repeat (2) @(posedge clk_sys_i);
        check("irq_o", {15'h0, irq_o}, 16'h1);
        check("request", {15'h0, conv_done_irq_o}, 16'h1);
        rd_reg(adcsq_pkg::OFS_RES_D, rv, 1'b1);
        check("dma result", rv, exp_res(3'h3));
        check("dma clears", {15'h0, conv_done_irq_o}, 16'h0);
        rd_reg(adcsq_pkg::OFS_CSR, rv);
        check("csr after dma", rv, 16'h004B);
        wr_reg(adcsq_pkg::OFS_IRQ_STAT, 16'h0003);
        repeat (2) @(posedge clk_sys_i);
        check("irq_o cleared", {15'h0, irq_o}, 16'h0);
        rd_reg(adcsq_pkg::OFS_IRQ_STAT, rv);
        check("irq status clear", rv, 16'h0000);
        wr_reg(adcsq_pkg::OFS_IRQ_MASK, 16'h0000);
    endtask : t_irq

    // Scan of inputs 4 to 6, then stop by software and by standby.
    task automatic t_scan();
        logic [2:0] q[$];
        logic [2:0] last;
        int n;
        last = 3'h7;
        n = 0;
        wr_reg(adcsq_pkg::OFS_CSR, 16'h007E);
        while (conv_done_irq_o !== 1'b1 && n < 1000) begin
            @(posedge clk_sys_i);
            n++;
            // The wrap to the half base lands with the request: skip it.
            if (conv_busy_o === 1'b1 && chan_sel_o !== last
                && conv_done_irq_o !== 1'b1) begin
                last = chan_sel_o;
                q.push_back(last);
            end
        end
        check("scans", 16'(q.size()), 16'h0003);
        for (int i = 0; i < 3 && i < q.size(); i++) begin
            check("scan chan", {13'h0, q[i]}, 16'(4 + i));
        end
        repeat (5) @(posedge clk_sys_i);
        check("scan goes on", {15'h0, conv_busy_o}, 16'h1);
        for (int i = 0; i < 3; i++) begin
            rd_reg(adcsq_pkg::OFS_RES_A + 28'(2 * i), rv);
            check("scan result", rv, exp_res(3'(4 + i)));
        end
        wr_reg(adcsq_pkg::OFS_CSR, 16'h005E);
        wait_busy(1'b0);
        wr_reg(adcsq_pkg::OFS_CSR, 16'h0038);
        wait_busy(1'b1);
        @(posedge clk_sys_i);
        standby_i <= 1'b1;
        repeat (2) @(posedge clk_sys_i);
        standby_i <= 1'b0;
        wait_busy(1'b0);
        rd_reg(adcsq_pkg::OFS_CSR, rv);
        check("csr after standby", rv, 16'h0004);
    endtask : t_scan

    task automatic complete_run();
        if (mismatches == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : complete_run

    // Guard against a hang; the whole run needs well under 6000 cycles.
    initial begin
        #(25 * 40000);
        mismatches++;
        complete_run();
    end

    initial begin
        repeat (10) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        t_reset();
        for (int i = 0; i < 8; i++) begin
            t_single(8'h28 | 8'(i), 134);
        end
        t_single(8'h22, 236);
        t_flag();
        t_irq();
        t_scan();
        complete_run();
    end
endmodule : testbench
